// ==== spi_status_panel.v ====
// Front panel status lamps and key decoding for the inverter
//
// Overview of operation
// RQ1: On activation the relay self-test runs before any other startup step.
// RQ2: After self-test, grid and battery conditions are checked, then operation starts.
// RQ3: DC lamp steady when DC sufficient; dark with no DC voltage.
// RQ4: DC lamp fast flash on low power; slow flash when voltage out of range.
// RQ5: Grid lamp flashes fast during activation.
// RQ6: Grid lamp slow flash during grid check, steady when grid is good.
// RQ7: Grid lamp dark when no grid is connected.
// RQ8: Wireless lamp steady linked, fast connecting, slow ready, dark otherwise.
// RQ9: Fault lamp steady on error, flashes in user-off, dark otherwise.
// RQ10: Clear key press under five seconds acknowledges the current error.
// RQ11: Clear key held over five seconds toggles the test mode.
// RQ12: In test mode the clear lamp and fault lamp flash fast together.
// RQ13: Update state: fault lamp steady, grid and DC lamps alternate.
// RQ14: Initialization: right and left lamps flash alternately.
// RQ15: No grid code: fault lamp dark, grid and DC lamps alternate.
// RQ16: Wireless key starts pairing; once paired its lamp lights blue.
// RQ17: Fast and slow flashing use fixed rates of about four and one hertz.
// RQ18: Update, initialization and no grid code patterns override normal lamp meanings.
`timescale 1ns/1ns
`default_nettype none
`include "spi_defs.vh"
module spi_status_panel #(
   parameter integer FAST_HALF = `SPI_FAST_HALF,
   parameter integer SLOW_HALF = `SPI_SLOW_HALF,
   parameter integer LONG_CYCLES = `SPI_LONG_CYCLES,
   parameter integer DEBOUNCE_CYCLES = `SPI_DEBOUNCE_CYCLES
) (
   // Clock, reset, enable
   input wire clk,
   input wire rst_n,
   input wire clk_en,
   // Startup sequencing
   input wire activate,
   input wire selftest_done,
   input wire selftest_fail,
   input wire conditions_ok,
   output reg selftest_start,
   output reg operating,
   // DC source status
   input wire dc_present,
   input wire dc_power_low,
   input wire dc_out_of_range,
   // Grid status
   input wire grid_present,
   input wire grid_check_busy,
   input wire grid_ok,
   // Wireless link status
   input wire link_up,
   input wire link_connecting,
   input wire link_ready,
   output reg pair_start,
   // Inverter state
   input wire error_active,
   input wire user_off,
   input wire update_mode,
   input wire init_mode,
   input wire no_grid_code,
   // Operator keys (raw pins, high while pressed)
   input wire clear_key_pin,
   input wire pair_key_pin,
   // Key results
   output reg error_ack,
   output reg test_mode,
   // Lamps
   output reg lamp_dc,
   output reg lamp_grid,
   output reg lamp_link,
   output reg lamp_fault,
   output reg lamp_clear
);
   // ------------------------------------------------------------
   // Flash rates
   // ------------------------------------------------------------
   wire fast_wave;
   wire slow_wave;

   spi_flash_gen #(.HALF(FAST_HALF)) u_fast ( // RQ17
      .clk(clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .wave(fast_wave)
   );

   spi_flash_gen #(.HALF(SLOW_HALF)) u_slow ( // RQ17
      .clk(clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .wave(slow_wave)
   );

   // ------------------------------------------------------------
   // Keys
   // ------------------------------------------------------------
   wire clear_short;
   wire clear_long;
   wire pair_short;
   wire pair_long;

   spi_key #(.DEBOUNCE(DEBOUNCE_CYCLES), .LONG(LONG_CYCLES)) u_clear_key (
      .clk(clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .key_pin(clear_key_pin),
      .short_press(clear_short),
      .long_press(clear_long)
   );

   spi_key #(.DEBOUNCE(DEBOUNCE_CYCLES), .LONG(LONG_CYCLES)) u_pair_key (
      .clk(clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .key_pin(pair_key_pin),
      .short_press(pair_short),
      .long_press(pair_long)
   );

   // ------------------------------------------------------------
   // Startup sequence
   // ------------------------------------------------------------
   reg [2:0] state_reg;
   reg [2:0] state_next;

   always @* begin
      state_next = state_reg;
      case (state_reg)
         `SPI_ST_IDLE: begin
            if (activate) begin
               state_next = `SPI_ST_SELFTEST; // RQ1
            end
         end
         `SPI_ST_SELFTEST: begin
            if (!activate) begin
               state_next = `SPI_ST_IDLE;
            end else if (selftest_done && !selftest_fail) begin
               state_next = `SPI_ST_CHECK; // RQ2
            end
         end
         `SPI_ST_CHECK: begin
            if (!activate) begin
               state_next = `SPI_ST_IDLE;
            end else if (conditions_ok) begin
               state_next = `SPI_ST_RUN; // RQ2
            end
         end
         `SPI_ST_RUN: begin
            if (!activate) begin
               state_next = `SPI_ST_IDLE;
            end
         end
         default: begin
            state_next = `SPI_ST_IDLE;
         end
      endcase
   end

   // A failed self-test holds the sequence in self-test until selftest_fail clears with selftest_done high, or activate drops
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= `SPI_ST_IDLE;
         selftest_start <= 1'b0;
         operating <= 1'b0;
      end else if (clk_en) begin
         state_reg <= state_next;
         selftest_start <= (state_reg == `SPI_ST_IDLE) && activate; // RQ1
         operating <= (state_next == `SPI_ST_RUN); // RQ2
      end
   end

   wire activating = (state_reg == `SPI_ST_SELFTEST);

   // ------------------------------------------------------------
   // Keys: acknowledge, test mode, pairing
   // ------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         error_ack <= 1'b0;
         test_mode <= 1'b0;
         pair_start <= 1'b0;
      end else if (clk_en) begin
         error_ack <= clear_short; // RQ10
         if (clear_long) begin
            test_mode <= ~test_mode; // RQ11
         end
         // Pairing starts on any release while link_up is low; a long hold still means pair
         pair_start <= (pair_short || pair_long) && !link_up; // RQ16
      end
   end

   // ------------------------------------------------------------
   // Lamp patterns
   // ------------------------------------------------------------
   reg [2:0] pat_dc;
   reg [2:0] pat_grid;
   reg [2:0] pat_link;
   reg [2:0] pat_fault;
   reg [2:0] pat_clear;

   always @* begin
      // Ordinary per-lamp meanings
      if (!dc_present) begin
         pat_dc = `SPI_PAT_OFF; // RQ3
      end else if (dc_out_of_range) begin
         pat_dc = `SPI_PAT_SLOW; // RQ4
      end else if (dc_power_low) begin
         pat_dc = `SPI_PAT_FAST; // RQ4
      end else begin
         pat_dc = `SPI_PAT_ON; // RQ3
      end
      if (activating) begin
         pat_grid = `SPI_PAT_FAST; // RQ5
      end else if (!grid_present) begin
         pat_grid = `SPI_PAT_OFF; // RQ7
      end else if (grid_check_busy) begin
         pat_grid = `SPI_PAT_SLOW; // RQ6
      end else if (grid_ok) begin
         pat_grid = `SPI_PAT_ON; // RQ6
      end else begin
         pat_grid = `SPI_PAT_SLOW;
      end
      if (link_up) begin
         pat_link = `SPI_PAT_ON; // RQ8 RQ16
      end else if (link_connecting) begin
         pat_link = `SPI_PAT_FAST; // RQ8
      end else if (link_ready) begin
         pat_link = `SPI_PAT_SLOW; // RQ8
      end else begin
         pat_link = `SPI_PAT_OFF; // RQ8
      end
      if (test_mode) begin
         pat_fault = `SPI_PAT_FAST; // RQ12
      end else if (error_active) begin
         pat_fault = `SPI_PAT_ON; // RQ9
      end else if (user_off) begin
         pat_fault = `SPI_PAT_SLOW; // RQ9
      end else begin
         pat_fault = `SPI_PAT_OFF; // RQ9
      end
      pat_clear = test_mode ? `SPI_PAT_FAST : `SPI_PAT_OFF; // RQ12
      // Whole-panel states take precedence
      if (update_mode) begin
         pat_fault = `SPI_PAT_ON; // RQ13 RQ18
         pat_grid = `SPI_PAT_ALT_A; // RQ13
         pat_dc = `SPI_PAT_ALT_B; // RQ13
      end else if (init_mode) begin
         // Grid and link on the right, DC and fault on the left
         pat_grid = `SPI_PAT_ALT_A; // RQ14 RQ18
         pat_link = `SPI_PAT_ALT_A; // RQ14
         pat_dc = `SPI_PAT_ALT_B; // RQ14
         pat_fault = `SPI_PAT_ALT_B; // RQ14
      end else if (no_grid_code) begin
         pat_fault = `SPI_PAT_OFF; // RQ15 RQ18
         pat_grid = `SPI_PAT_ALT_A; // RQ15
         pat_dc = `SPI_PAT_ALT_B; // RQ15
      end
   end

   function lamp_level;
      input [2:0] pat;
      input fast;
      input slow;
      begin
         case (pat)
            `SPI_PAT_ON: lamp_level = 1'b1;
            `SPI_PAT_FAST: lamp_level = fast;
            `SPI_PAT_SLOW: lamp_level = slow;
            `SPI_PAT_ALT_A: lamp_level = slow;
            `SPI_PAT_ALT_B: lamp_level = ~slow;
            default: lamp_level = 1'b0;
         endcase
      end
   endfunction

   // Both fast lamps share one generator, so test-mode flashing stays in step
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lamp_dc <= 1'b0;
         lamp_grid <= 1'b0;
         lamp_link <= 1'b0;
         lamp_fault <= 1'b0;
         lamp_clear <= 1'b0;
      end else if (clk_en) begin
         lamp_dc <= lamp_level(pat_dc, fast_wave, slow_wave);
         lamp_grid <= lamp_level(pat_grid, fast_wave, slow_wave);
         lamp_link <= lamp_level(pat_link, fast_wave, slow_wave);
         lamp_fault <= lamp_level(pat_fault, fast_wave, slow_wave); // RQ12
         lamp_clear <= lamp_level(pat_clear, fast_wave, slow_wave); // RQ12
      end
   end
endmodule
`default_nettype wire

// ==== spi_defs.vh ====
// Constants for the status panel indicator logic
`ifndef SPI_DEFS_VH
`define SPI_DEFS_VH

// Clock and timing
`define SPI_CLK_HZ 250000000
`define SPI_FAST_HZ 4
`define SPI_SLOW_HZ 1
`define SPI_LONG_PRESS_S 5
// Half periods in cycles; the flash toggles every half period
`define SPI_FAST_HALF (`SPI_CLK_HZ / (2 * `SPI_FAST_HZ))
`define SPI_SLOW_HALF (`SPI_CLK_HZ / (2 * `SPI_SLOW_HZ))
`define SPI_LONG_CYCLES (`SPI_CLK_HZ * `SPI_LONG_PRESS_S)
// Key debounce, in milliseconds and cycles
`define SPI_DEBOUNCE_MS 10
`define SPI_DEBOUNCE_CYCLES (`SPI_CLK_HZ / 1000 * `SPI_DEBOUNCE_MS)

// Startup sequence states
`define SPI_ST_IDLE 3'h0
`define SPI_ST_SELFTEST 3'h1
`define SPI_ST_CHECK 3'h2
`define SPI_ST_RUN 3'h3

// Lamp pattern codes
`define SPI_PAT_OFF 3'h0
`define SPI_PAT_ON 3'h1
`define SPI_PAT_FAST 3'h2
`define SPI_PAT_SLOW 3'h3
`define SPI_PAT_ALT_A 3'h4
`define SPI_PAT_ALT_B 3'h5

`endif

// ==== spi_flash_gen.v ====
// Free running flash rate generator
`timescale 1ns/1ns
`default_nettype none
module spi_flash_gen #(
   parameter integer HALF = 1000
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   input wire clk_en,
   // Square wave
   output reg wave
);
   reg [31:0] cnt_reg;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 32'h0;
         wave <= 1'b0;
      end else if (clk_en) begin
         if (cnt_reg >= HALF - 1) begin
            cnt_reg <= 32'h0;
            wave <= ~wave;
         end else begin
            cnt_reg <= cnt_reg + 32'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== spi_key.v ====
// Key synchroniser, debouncer and press length timer
`timescale 1ns/1ns
`default_nettype none
module spi_key #(
   parameter integer DEBOUNCE = 1000,
   parameter integer LONG = 5000
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   input wire clk_en,
   // Raw key pin, high while pressed
   input wire key_pin,
   // One cycle pulses on release
   output reg short_press,
   output reg long_press
);
   reg sync1_reg;
   reg sync2_reg;
   reg stable_reg;
   reg [31:0] db_reg;
   reg [31:0] hold_reg;
   reg long_seen_reg;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         stable_reg <= 1'b0;
         db_reg <= 32'h0;
         hold_reg <= 32'h0;
         long_seen_reg <= 1'b0;
         short_press <= 1'b0;
         long_press <= 1'b0;
      end else if (clk_en) begin
         sync1_reg <= key_pin;
         sync2_reg <= sync1_reg;
         short_press <= 1'b0;
         long_press <= 1'b0;
         // Accept a new level only after it stood for the whole debounce time
         if (sync2_reg == stable_reg) begin
            db_reg <= 32'h0;
         end else if (db_reg >= DEBOUNCE - 1) begin
            db_reg <= 32'h0;
            stable_reg <= sync2_reg;
            if (!sync2_reg) begin
               // Release: length decides the meaning
               if (long_seen_reg) begin
                  long_press <= 1'b1;
               end else begin
                  short_press <= 1'b1;
               end
            end
            hold_reg <= 32'h0;
            long_seen_reg <= 1'b0;
         end else begin
            db_reg <= db_reg + 32'h1;
         end
         // Count only while the level is settled, so the clear on release is not undone
         if (stable_reg && !long_seen_reg && sync2_reg == stable_reg) begin
            if (hold_reg >= LONG - 1) begin
               long_seen_reg <= 1'b1;
            end else begin
               hold_reg <= hold_reg + 32'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== spi_status_panel_assertions.sv ====
// Concurrent checks on the status panel ports
`timescale 1ns/1ns
`default_nettype none
module spi_status_panel_chk #(
   parameter integer FAST_HALF = 4,
   parameter integer SLOW_HALF = 16,
   parameter integer LONG_CYCLES = 100,
   parameter integer DEBOUNCE_CYCLES = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Inputs
   input wire logic activate,
   input wire logic conditions_ok,
   input wire logic dc_present,
   input wire logic grid_present,
   input wire logic link_up,
   input wire logic error_active,
   input wire logic user_off,
   input wire logic update_mode,
   input wire logic init_mode,
   input wire logic no_grid_code,
   input wire logic clear_key_pin,
   // Outputs
   input wire logic selftest_start,
   input wire logic operating,
   input wire logic pair_start,
   input wire logic error_ack,
   input wire logic test_mode,
   input wire logic lamp_dc,
   input wire logic lamp_grid,
   input wire logic lamp_link,
   input wire logic lamp_fault,
   input wire logic lamp_clear
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire plain = !update_mode && !init_mode && !no_grid_code;
   sequence s_start_pulse;
      $past(activate) && !operating ##1 !selftest_start;
   endsequence
   sequence s_ack_pulse;
      $stable(test_mode) ##1 !error_ack;
   endsequence
   a_start_first: assert property ($rose(selftest_start) |-> s_start_pulse)
      else $error("self-test start not a single pulse after activation");
   a_run_cause: assert property ($rose(operating) |-> $past(conditions_ok) && $past(activate))
      else $error("operation began without connection conditions");
   a_run_drop: assert property (!activate |=> !operating)
      else $error("operating stayed high after deactivation");
   a_dc_dark: assert property (!dc_present && plain |=> !lamp_dc)
      else $error("dc lamp lit without dc voltage");
   a_grid_dark: assert property (!grid_present && !activate && !$past(activate) && plain |=> !lamp_grid)
      else $error("grid lamp lit without grid");
   a_fault_dark: assert property (!error_active && !user_off && !test_mode && plain |=> !lamp_fault)
      else $error("fault lamp lit without error");
   a_test_sync: assert property (test_mode && $past(test_mode) && $past(plain) |-> lamp_fault == lamp_clear)
      else $error("clear and fault lamps out of step in test mode");
   a_update_alt: assert property ($past(update_mode) |-> lamp_fault && lamp_grid != lamp_dc)
      else $error("update pattern wrong");
   a_init_alt: assert property ($past(init_mode) && !$past(update_mode) |->
      lamp_grid == lamp_link && lamp_dc == lamp_fault && lamp_grid != lamp_dc)
      else $error("initialization pattern wrong");
   a_nogrid_alt: assert property ($past(no_grid_code) && !$past(update_mode) && !$past(init_mode) |->
      !lamp_fault && lamp_grid != lamp_dc)
      else $error("missing grid code pattern wrong");
   a_ack_short: assert property (error_ack |-> s_ack_pulse)
      else $error("acknowledge pulse wrong");
   a_long_toggle: assert property ($changed(test_mode) |-> !$past(clear_key_pin) && !error_ack)
      else $error("test mode changed while key held");
   a_pair_pulse: assert property (pair_start |-> !$past(link_up) ##1 !pair_start)
      else $error("pairing start pulse wrong");
endmodule
bind spi_status_panel spi_status_panel_chk #(.FAST_HALF(FAST_HALF), .SLOW_HALF(SLOW_HALF),
   .LONG_CYCLES(LONG_CYCLES), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_chk (.clk(clk), .rst_n(rst_n),
   .activate(activate), .conditions_ok(conditions_ok), .dc_present(dc_present), .grid_present(grid_present),
   .link_up(link_up), .error_active(error_active), .user_off(user_off), .update_mode(update_mode),
   .init_mode(init_mode), .no_grid_code(no_grid_code), .clear_key_pin(clear_key_pin),
   .selftest_start(selftest_start), .operating(operating), .pair_start(pair_start), .error_ack(error_ack),
   .test_mode(test_mode), .lamp_dc(lamp_dc), .lamp_grid(lamp_grid), .lamp_link(lamp_link),
   .lamp_fault(lamp_fault), .lamp_clear(lamp_clear));
`default_nettype wire

// ==== spi_keypad_model.sv ====
// Operator keypad model: one key pressed at a time, with a contact bounce
`timescale 1ns/1ns
`default_nettype none
module spi_keypad_model (
   // Clock
   input wire logic clk,
   // Press request
   input wire logic go,
   input wire logic sel,
   input wire logic [7:0] len,
   // Key pins, high while pressed, low when released
   output logic clear_key_pin,
   output logic pair_key_pin,
   output logic busy
);
   // ----------------------------------------
   // Press timing
   // ----------------------------------------
   logic [8:0] cnt = 9'h000;
   logic lvl;
   always @(posedge clk) begin
      if (go && cnt == 9'h000) begin
         cnt <= {1'b0, len} + 9'h003;
      end else if (cnt != 9'h000) begin
         cnt <= cnt - 9'h001;
      end
   end
   // One cycle gap after contact: a bounce far shorter than any debounce window
   assign lvl = cnt != 9'h000 && cnt != {1'b0, len} + 9'h002;
   assign clear_key_pin = lvl && !sel;
   assign pair_key_pin = lvl && sel;
   assign busy = cnt != 9'h000;
endmodule
`default_nettype wire

// ==== test_spi_status_panel.sv ====
// Self-checking bench for the status panel lamps, keys and startup
`timescale 1ns/1ns
`default_nettype none
module test_spi_status_panel;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic clk, rst_n, act, st_done, st_fail, cond_ok, go, sel;
   logic en = 1'b1;
   logic [7:0] len;
   logic [13:0] st;
   int bad_count = 0;
   int compares = 0;
   wire dc_present, dc_power_low, dc_out_of_range, grid_present, grid_check_busy, grid_ok, link_up;
   wire link_connecting, link_ready, error_active, user_off, update_mode, init_mode, no_grid_code;
   wire clear_key_pin, pair_key_pin, busy;
   logic selftest_start, operating, pair_start, error_ack, test_mode;
   logic lamp_dc, lamp_grid, lamp_link, lamp_fault, lamp_clear;
   assign {dc_present, dc_power_low, dc_out_of_range, grid_present, grid_check_busy, grid_ok, link_up,
      link_connecting, link_ready, error_active, user_off, update_mode, init_mode, no_grid_code} = st;
   wire [6:0] mon = {!operating, !test_mode, test_mode, pair_start, error_ack, operating, selftest_start};
   wire [4:0] lamps = {lamp_dc, lamp_grid, lamp_link, lamp_fault, lamp_clear};
   // Rows: inputs, lamp codes dc/grid/link/fault (0 off, 1 on, 2 fast, 3 slow), mask
   logic [29:0] rows [15] = '{{14'h2000, 8'h40, 8'hff}, {14'h3000, 8'h80, 8'hff}, {14'h2800, 8'hc0, 8'hff},
      {14'h0000, 8'h00, 8'hff}, {14'h0600, 8'h30, 8'hff}, {14'h0500, 8'h10, 8'hff}, {14'h0080, 8'h04, 8'hff},
      {14'h0040, 8'h08, 8'hff}, {14'h0020, 8'h0c, 8'hff}, {14'h0010, 8'h01, 8'hff}, {14'h0008, 8'h03, 8'hff},
      {14'h2514, 8'hf1, 8'hf3}, {14'h0002, 8'hff, 8'hff}, {14'h0011, 8'hf0, 8'hf3}, {14'h0004, 8'hf1, 8'hf3}};

   spi_status_panel #(.FAST_HALF(4), .SLOW_HALF(16), .LONG_CYCLES(100), .DEBOUNCE_CYCLES(4)) DUT (
      .clk(clk), .rst_n(rst_n), .clk_en(en), .activate(act), .selftest_done(st_done),
      .selftest_fail(st_fail), .conditions_ok(cond_ok), .selftest_start(selftest_start), .operating(operating),
      .dc_present(dc_present), .dc_power_low(dc_power_low), .dc_out_of_range(dc_out_of_range),
      .grid_present(grid_present), .grid_check_busy(grid_check_busy), .grid_ok(grid_ok), .link_up(link_up),
      .link_connecting(link_connecting), .link_ready(link_ready), .pair_start(pair_start),
      .error_active(error_active), .user_off(user_off), .update_mode(update_mode), .init_mode(init_mode),
      .no_grid_code(no_grid_code), .clear_key_pin(clear_key_pin), .pair_key_pin(pair_key_pin),
      .error_ack(error_ack), .test_mode(test_mode), .lamp_dc(lamp_dc), .lamp_grid(lamp_grid),
      .lamp_link(lamp_link), .lamp_fault(lamp_fault), .lamp_clear(lamp_clear));
   spi_keypad_model keys (.clk(clk), .go(go), .sel(sel), .len(len), .clear_key_pin(clear_key_pin),
      .pair_key_pin(pair_key_pin), .busy(busy));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task test_done;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task expire;
      check(32'h0, 32'h1);
      test_done;
   endtask
   // Waits for one monitored output to be high, sampled just after each edge
   task automatic await(input int b, input int lim);
      for (int i = 0; mon[b] !== 1'b1; i++) begin
         if (i == lim) expire;
         @(posedge clk);
         #1;
      end
      compares++;
   endtask
   task automatic press(input logic s, input logic [7:0] n);
      sel = s;
      len = n;
      go = 1'b1;
      @(posedge clk);
      #1 go = 1'b0;
      for (int i = 0; busy; i++) begin
         if (i == 300) expire;
         @(posedge clk);
         #1;
      end
   endtask
   // Counts lamp toggles over 64 cycles: fast toggles 16 times, slow 4
   task automatic look(output logic [9:0] c);
      int n [5];
      logic [4:0] p, q;
      repeat (3) @(posedge clk);
      #1 p = lamps;
      q = p;
      foreach (n[k]) n[k] = 0;
      repeat (64) begin
         @(posedge clk);
         #1 q = lamps;
         foreach (n[k]) n[k] += (q[k] !== p[k]);
         p = q;
      end
      foreach (n[k]) c[2*k+:2] = n[k] > 10 ? 2'd2 : n[k] > 1 ? 2'd3 : {1'b0, q[k]};
   endtask

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      logic [9:0] c;
      {rst_n, act, st_done, st_fail, cond_ok, go, sel, len, st} = '0;
      repeat (12) @(posedge clk);
      #1 rst_n = 1'b1;
      act = 1'b1;
      cond_ok = 1'b1;
      await(0, 10);
      look(c);
      check(c[7:6], 2'd2);
      check(operating, 1'b0);
      st_done = 1'b1;
      st_fail = 1'b1;
      repeat (8) @(posedge clk);
      #1 check(operating, 1'b0);
      st_fail = 1'b0;
      await(1, 10);
      act = 1'b0;
      await(6, 5);
      $display("test startup done");
      for (int i = 0; i < 15; i++) begin
         st = rows[i][29:16];
         look(c);
         check(c[9:2] & rows[i][7:0], rows[i][15:8]);
      end
      $display("test lamps done");
      st = 14'h0010;
      press(1'b0, 8'd20);
      await(2, 30);
      check(test_mode, 1'b0);
      press(1'b0, 8'd150);
      await(4, 30);
      look(c);
      check(c[3:0], 4'ha);
      press(1'b0, 8'd150);
      await(5, 30);
      press(1'b1, 8'd20);
      await(3, 30);
      $display("test keys done");
      // Enable low must freeze a lamp that would otherwise flash fast
      st = 14'h3000;
      repeat (3) @(posedge clk);
      #1 en = 1'b0;
      look(c);
      check(c[9], 1'b0);
      en = 1'b1;
      look(c);
      check(c[9:8], 2'd2);
      $display("test enable done");
      test_done;
   end
endmodule
`default_nettype wire
